// file: rtl/flcfg_defines.svh
`ifndef FLCFG_DEFINES_SVH
`define FLCFG_DEFINES_SVH
// How it works
// - Activate bit 0 enables floppy device
// - Base address pair, 100h..FF8h, 8-byte aligned
// - Low nibble picks host interrupt line
// - DMA field routes request; top bit disables
// - Mode bit 6 sets drive pin polarity
// - Mode bit 5 low reports second drive, in model B only
// - Mode bit 4 swaps drive/motor selects
// - Interface field selects host register emulation
// - Mode bit 1 chooses burst or non-burst DMA
// - Boot field 00 designates drive A
// - Media ID bits appear on tape register
// - Density field forces density output level for drive types 0 and 2
// - Write inhibit holds write pins high
// - Soft write protect overrides drive input
// - Drive config bit 6 disables precompensation
// - Rate table field selects rate table
// - Rate codes map to rates and density
// - Drive type picks density pin source

// -----------------------------------------------------------------
// Register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define FLCFG_IDX_ACTIVATE 8'h30
`define FLCFG_IDX_BASE_HI 8'h60
`define FLCFG_IDX_BASE_LO 8'h61
`define FLCFG_IDX_IRQ 8'h70
`define FLCFG_IDX_DMA 8'h74
`define FLCFG_IDX_MODE 8'hF0
`define FLCFG_IDX_MEDIA 8'hF1
`define FLCFG_IDX_DTYPE_A 8'hF2
`define FLCFG_IDX_RATE0 8'hF4
`define FLCFG_IDX_RATE1 8'hF5

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define FLCFG_RST_ACTIVATE 8'h01
`define FLCFG_RST_BASE_HI 8'h03
`define FLCFG_RST_BASE_LO 8'hF0
`define FLCFG_RST_IRQ 8'h06
`define FLCFG_RST_DMA 8'h02
`define FLCFG_RST_MODE 8'h8E
`define FLCFG_RST_MEDIA 8'h00
`define FLCFG_RST_DTYPE_A 8'hFF
`define FLCFG_RST_RATE 8'h00

// -----------------------------------------------------------------
// Writable bit masks
// -----------------------------------------------------------------
`define FLCFG_WM_ACTIVATE 8'h01
`define FLCFG_WM_BASE_HI 8'h0F
`define FLCFG_WM_BASE_LO 8'hF8
`define FLCFG_WM_IRQ 8'h0F
`define FLCFG_WM_DMA 8'h07
`define FLCFG_WM_MODE 8'h7F
`define FLCFG_WM_MEDIA 8'hFF
`define FLCFG_WM_DTYPE_A 8'h03
`define FLCFG_WM_RATE 8'h5B

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define FLCFG_ACT_BIT 0
`define FLCFG_MODE_POL_BIT 6
`define FLCFG_MODE_NO2ND_BIT 5
`define FLCFG_MODE_SWAP_BIT 4
`define FLCFG_MODE_IF_HI 3
`define FLCFG_MODE_IF_LO 2
`define FLCFG_MODE_NOBURST_BIT 1
`define FLCFG_MODE_FLOPPY_BIT 0
`define FLCFG_MED_BOOT_HI 7
`define FLCFG_MED_BOOT_LO 6
`define FLCFG_MED_ID_HI 5
`define FLCFG_MED_ID_LO 4
`define FLCFG_MED_DEN_HI 3
`define FLCFG_MED_DEN_LO 2
`define FLCFG_MED_WINH_BIT 1
`define FLCFG_MED_SOFT_WRITE_PROTECT_BIT 0
`define FLCFG_RATE_NOPC_BIT 6
`define FLCFG_RATE_TBL_HI 4
`define FLCFG_RATE_TBL_LO 3
`define FLCFG_RATE_DT_HI 1
`define FLCFG_RATE_DT_LO 0
`define FLCFG_DMA_OFF_BIT 2

// -----------------------------------------------------------------
// Data rates in kbit/s
// -----------------------------------------------------------------
`define FLCFG_KBPS_1M 12'h3E8
`define FLCFG_KBPS_500 12'h1F4
`define FLCFG_KBPS_300 12'h12C
`define FLCFG_KBPS_250 12'h0FA
`define FLCFG_KBPS_2M 12'h7D0
`define FLCFG_KBPS_150 12'h096
`define FLCFG_KBPS_125 12'h07D
`define FLCFG_KBPS_NONE 12'h000

`endif

// file: rtl/flcfg_pkg.sv
package flcfg_pkg;
  // Host register emulation models
  typedef enum logic [1:0] {
    FLCFG_IF_MODEL_A = 2'h0,
    FLCFG_IF_MODEL_B = 2'h1,
    FLCFG_IF_RSVD = 2'h2,
    FLCFG_IF_DESKTOP = 2'h3
  } flcfg_iface_e;
  // Register byte lane
  typedef logic [7:0] flcfg_byte_t;
endpackage

// file: rtl/flcfg_regs.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "flcfg_defines.svh"
module flcfg_regs
  import flcfg_pkg::*;
#(
  parameter int NREG = 10
) (
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device configuration outputs
  output logic dev_active,
  output logic [11:0] io_base,
  output logic io_base_valid,
  output logic [3:0] irq_line_sel,
  output logic burst_en,
  output logic floppy_mode,
  output flcfg_iface_e iface_mode,
  output logic second_drive_report,
  output logic boot_from_a,
  output logic [1:0] tape_media_id,
  output logic [1:0] drive_a_type_sel,
  output logic [1:0] precomp_en,
  output logic [11:0] mfm_rate_kbps,
  output logic [11:0] fm_rate_kbps,
  // Controller core side, active high
  input wire logic core_dma_req,
  input wire logic [1:0] rate_code,
  input wire logic drive_num,
  input wire logic [1:0] core_drive_sel,
  input wire logic [1:0] core_motor_on,
  input wire logic core_write_gate,
  input wire logic core_write_data,
  output logic core_write_protect,
  // Host DMA request lines
  output logic [3:0] dma_req_out,
  // Drive pins, at pin polarity
  output logic [1:0] drive_sel_pin,
  output logic [1:0] motor_on_pin,
  output logic write_gate_pin,
  output logic write_data_out,
  output logic drive_density_out,
  input wire logic write_protect_pin
);

  // -----------------------------------------------------------------
  // Register table
  // -----------------------------------------------------------------
  // Index, writable mask and reset value of each register
  localparam logic [7:0] IDX [NREG] = '{`FLCFG_IDX_ACTIVATE, `FLCFG_IDX_BASE_HI,
    `FLCFG_IDX_BASE_LO, `FLCFG_IDX_IRQ, `FLCFG_IDX_DMA, `FLCFG_IDX_MODE,
    `FLCFG_IDX_MEDIA, `FLCFG_IDX_DTYPE_A, `FLCFG_IDX_RATE0, `FLCFG_IDX_RATE1};
  localparam logic [7:0] WMASK [NREG] = '{`FLCFG_WM_ACTIVATE, `FLCFG_WM_BASE_HI,
    `FLCFG_WM_BASE_LO, `FLCFG_WM_IRQ, `FLCFG_WM_DMA, `FLCFG_WM_MODE,
    `FLCFG_WM_MEDIA, `FLCFG_WM_DTYPE_A, `FLCFG_WM_RATE, `FLCFG_WM_RATE};
  localparam logic [7:0] RSTV [NREG] = '{`FLCFG_RST_ACTIVATE, `FLCFG_RST_BASE_HI,
    `FLCFG_RST_BASE_LO, `FLCFG_RST_IRQ, `FLCFG_RST_DMA, `FLCFG_RST_MODE,
    `FLCFG_RST_MEDIA, `FLCFG_RST_DTYPE_A, `FLCFG_RST_RATE, `FLCFG_RST_RATE};
  // Slot numbers into the table
  localparam int S_ACT = 0;
  localparam int S_BHI = 1;
  localparam int S_BLO = 2;
  localparam int S_IRQ = 3;
  localparam int S_DMA = 4;
  localparam int S_MODE = 5;
  localparam int S_MED = 6;
  localparam int S_DTA = 7;
  localparam int S_R0 = 8;

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  logic wr_pend_q; // Write data phase in progress
  logic [NREG-1:0] wr_hit_q; // Which register the pending write targets
  logic rd_pend_q; // Read wait cycle
  logic rd_out_q; // Read data cycle
  logic [NREG-1:0] rd_hit_q; // Which register the pending read targets
  logic [31:0] hrdata_q; // Registered read data
  flcfg_byte_t regs_q [NREG]; // Register contents

  wire take = hsel & htrans[1] & hready;
  // Only aligned word accesses hit a register; anything else reads zero
  wire word_ok = (hsize == 3'h2) & (haddr[1:0] == 2'h0) & (haddr[31:10] == 22'h0);
  wire [7:0] idx = haddr[9:2];
  wire [NREG-1:0] hit;
  logic [7:0] rd_val; // Byte picked by the pending read

  // Reads stall one cycle so the data always reflects the previous write
  assign hreadyout = ~rd_pend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // -----------------------------------------------------------------
  // Per-register storage
  // -----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hit[gi] = word_ok & (idx == IDX[gi]);
      // Reserved bits hold their default and ignore writes
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          regs_q[gi] <= RSTV[gi];
        end else if (wr_pend_q && wr_hit_q[gi]) begin
          regs_q[gi] <= (hwdata[7:0] & WMASK[gi]) | (RSTV[gi] & ~WMASK[gi]);
        end
      end
    end
  endgenerate

  // One-hot select of the register being read
  always_comb begin
    rd_val = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (rd_hit_q[i]) begin
        rd_val = rd_val | regs_q[i];
      end
    end
  end

  // Address phase capture and data phase sequencing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_hit_q <= '0;
      rd_pend_q <= 1'b0;
      rd_out_q <= 1'b0;
      rd_hit_q <= '0;
    end else begin
      wr_pend_q <= take & hwrite;
      wr_hit_q <= (take & hwrite) ? hit : '0;
      rd_pend_q <= take & ~hwrite;
      rd_out_q <= rd_pend_q;
      rd_hit_q <= (take & ~hwrite) ? hit : rd_hit_q;
    end
  end

  // Read data loads during the wait cycle, zero otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h0;
    end else if (rd_pend_q) begin
      hrdata_q <= {24'h0, rd_val};
    end else begin
      hrdata_q <= 32'h0;
    end
  end

  // -----------------------------------------------------------------
  // Configuration decode
  // -----------------------------------------------------------------
  wire [7:0] mode = regs_q[S_MODE];
  wire [7:0] med = regs_q[S_MED];
  wire pol_high = mode[`FLCFG_MODE_POL_BIT];
  wire swap = mode[`FLCFG_MODE_SWAP_BIT];
  wire [1:0] den_force = med[`FLCFG_MED_DEN_HI:`FLCFG_MED_DEN_LO];
  wire write_inhibit = med[`FLCFG_MED_WINH_BIT];
  wire soft_write_protect = med[`FLCFG_MED_SOFT_WRITE_PROTECT_BIT];
  wire [2:0] dma_sel = regs_q[S_DMA][2:0];

  assign dev_active = regs_q[S_ACT][`FLCFG_ACT_BIT];
  // Low three bits are never stored, so the base is always 8-byte aligned
  assign io_base = {regs_q[S_BHI][3:0], regs_q[S_BLO]};
  assign io_base_valid = (regs_q[S_BHI][3:0] != 4'h0);
  assign irq_line_sel = regs_q[S_IRQ][3:0];
  assign burst_en = ~mode[`FLCFG_MODE_NOBURST_BIT];
  assign floppy_mode = mode[`FLCFG_MODE_FLOPPY_BIT];
  assign iface_mode = flcfg_iface_e'(mode[`FLCFG_MODE_IF_HI:`FLCFG_MODE_IF_LO]);
  assign second_drive_report = ~mode[`FLCFG_MODE_NO2ND_BIT]
    & (iface_mode == FLCFG_IF_MODEL_B);
  assign boot_from_a = (med[`FLCFG_MED_BOOT_HI:`FLCFG_MED_BOOT_LO] == 2'h0);
  assign tape_media_id = med[`FLCFG_MED_ID_HI:`FLCFG_MED_ID_LO];
  assign drive_a_type_sel = regs_q[S_DTA][1:0];

  // -----------------------------------------------------------------
  // DMA request routing
  // -----------------------------------------------------------------
  // An inactive device never raises a request
  genvar gd;
  generate
    for (gd = 0; gd < 4; gd++) begin : g_dma
      assign dma_req_out[gd] = core_dma_req & dev_active & ~dma_sel[`FLCFG_DMA_OFF_BIT]
        & (dma_sel[1:0] == 2'(gd));
    end
  endgenerate

  // -----------------------------------------------------------------
  // Drive pins
  // -----------------------------------------------------------------
  wire [1:0] sel_sw = swap ? {core_drive_sel[0], core_drive_sel[1]} : core_drive_sel;
  wire [1:0] mot_sw = swap ? {core_motor_on[0], core_motor_on[1]} : core_motor_on;
  // Internal signals are active high; pins invert when polarity is low
  assign drive_sel_pin = pol_high ? sel_sw : ~sel_sw;
  assign motor_on_pin = pol_high ? mot_sw : ~mot_sw;
  // Inhibit drives the pin level high whatever the polarity
  assign write_gate_pin = write_inhibit | (pol_high ? core_write_gate : ~core_write_gate);
  assign write_data_out = write_inhibit | (pol_high ? core_write_data : ~core_write_data);
  wire wp_in = pol_high ? write_protect_pin : ~write_protect_pin;
  assign core_write_protect = soft_write_protect | wp_in;

  // -----------------------------------------------------------------
  // Per-drive rate tables and density
  // -----------------------------------------------------------------
  logic [1:0] den_drv; // Density pin level per drive, before polarity
  logic [11:0] mfm_drv [2]; // MFM rate per drive
  logic [11:0] fm_drv [2]; // FM rate per drive
  genvar gr;
  generate
    for (gr = 0; gr < 2; gr++) begin : g_drv
      wire [7:0] rc = regs_q[S_R0 + gr];
      wire [1:0] tbl = rc[`FLCFG_RATE_TBL_HI:`FLCFG_RATE_TBL_LO];
      wire [1:0] dtype = rc[`FLCFG_RATE_DT_HI:`FLCFG_RATE_DT_LO];
      assign precomp_en[gr] = ~rc[`FLCFG_RATE_NOPC_BIT];
      // Density select high only for the two fastest standard codes
      wire den_raw = (rate_code == 2'h3) | (rate_code == 2'h0);
      wire den_sel = (den_force == 2'h2) ? 1'b1 : (den_force == 2'h3) ? 1'b0 : den_raw;
      // Rate table; the reserved table code behaves as the regular table
      always_comb begin
        mfm_drv[gr] = `FLCFG_KBPS_1M;
        fm_drv[gr] = `FLCFG_KBPS_NONE;
        case (rate_code)
          2'h3: begin
            mfm_drv[gr] = `FLCFG_KBPS_1M;
          end
          2'h0: begin
            mfm_drv[gr] = `FLCFG_KBPS_500;
            fm_drv[gr] = `FLCFG_KBPS_250;
          end
          2'h2: begin
            mfm_drv[gr] = `FLCFG_KBPS_250;
            fm_drv[gr] = `FLCFG_KBPS_125;
          end
          default: begin
            if (tbl == 2'h1) begin
              mfm_drv[gr] = `FLCFG_KBPS_500;
              fm_drv[gr] = `FLCFG_KBPS_250;
            end else if (tbl == 2'h2) begin
              mfm_drv[gr] = `FLCFG_KBPS_2M;
            end else begin
              mfm_drv[gr] = `FLCFG_KBPS_300;
              fm_drv[gr] = `FLCFG_KBPS_150;
            end
          end
        endcase
      end
      // Drive type picks what the density pin carries
      always_comb begin
        case (dtype)
          2'h1: den_drv[gr] = rate_code[1];
          2'h3: den_drv[gr] = rate_code[0];
          default: den_drv[gr] = den_sel;
        endcase
      end
    end
  endgenerate

  // The density pin and the rate follow the drive being addressed
  assign drive_density_out = pol_high ? den_drv[drive_num] : ~den_drv[drive_num];
  assign mfm_rate_kbps = mfm_drv[drive_num];
  assign fm_rate_kbps = fm_drv[drive_num];

endmodule

// file: dv/flcfg_regs_sva.sv
`timescale 1ns/1ps
module flcfg_regs_sva
  import flcfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic dev_active,
  input wire logic [11:0] io_base,
  input wire logic io_base_valid,
  input wire flcfg_iface_e iface_mode,
  input wire logic second_drive_report,
  input wire logic burst_en,
  input wire logic core_dma_req,
  input wire logic [3:0] dma_req_out
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (rst);
  logic taken; // Transfer accepted at this edge
  logic wdp_q; // Write data phase in progress
  assign taken = hsel & htrans[1] & hready;
  // A setting may only move right after a write data phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdp_q <= 1'b0;
    end else begin
      wdp_q <= taken & hwrite;
    end
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase timing wrong");
  a_write_ready: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bytes not zero");
  a_dma_onehot: assert property ($onehot0(dma_req_out))
    else $error("more than one dma channel requested");
  a_dma_cause: assert property (|dma_req_out |-> core_dma_req && dev_active)
    else $error("dma request without cause");
  a_base_align: assert property (io_base[2:0] == 3'h0)
    else $error("base address not eight byte aligned");
  a_base_range: assert property (io_base_valid == (io_base >= 12'h100))
    else $error("base address valid flag wrong");
  a_second_drive: assert property (second_drive_report |-> iface_mode == FLCFG_IF_MODEL_B)
    else $error("second drive reported outside model b");
  a_burst_hold: assert property ($changed(burst_en) |-> $past(wdp_q))
    else $error("burst mode changed without a write");
  c_read: cover property (taken && !hwrite);
  c_dma: cover property (|dma_req_out);
  c_second: cover property (second_drive_report);
endmodule
bind flcfg_regs flcfg_regs_sva flcfg_regs_sva_i (.clock, .rst, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .dev_active, .io_base, .io_base_valid, .iface_mode,
  .second_drive_report, .burst_en, .core_dma_req, .dma_req_out);

// file: dv/flcfg_drive_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Drive side: write-protect sense at the chosen pin polarity
// ------------------------------------------------------------
module flcfg_drive_model (
  input wire logic wp_on,
  input wire logic pol_high,
  output logic write_protect_pin
);
  // A protected disk drives the pin to its active level
  assign write_protect_pin = pol_high ? wp_on : ~wp_on;
endmodule

// file: dv/floppy_ctrl_config_regs_tb.sv
`timescale 1ns/1ps
module floppy_ctrl_config_regs_tb;
  import flcfg_pkg::*;
  // ------------------------------------------------------------
  // Signals and tables
  // ------------------------------------------------------------
  logic clock = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic [1:0] htrans = 2'h0, rate_code = 2'h0, core_drive_sel = 2'h1, core_motor_on = 2'h1;
  logic [1:0] tape_media_id, precomp_en, drive_sel_pin, motor_on_pin, e;
  logic [2:0] hsize = 3'h2;
  logic [11:0] io_base, mfm_rate_kbps, fm_rate_kbps;
  logic [3:0] irq_line_sel, dma_req_out;
  flcfg_iface_e iface_mode;
  logic dev_active, io_base_valid, burst_en, second_drive_report, boot_from_a, s;
  logic core_dma_req = 1'b0, drive_num = 1'b0, core_write_gate = 1'b1, core_write_data = 1'b0;
  logic core_write_protect, write_gate_pin, write_data_out, drive_density_out;
  logic write_protect_pin, wp_on = 1'b0, pol_high = 1'b0;
  logic [7:0] m;
  logic floppy_mode;
  logic [1:0] drive_a_type_sel;
  // Bus answers as they stood just before the next rising edge
  logic rdy_s = 1'b1;
  logic [31:0] rdat_s = 32'h0;
  int bad_count = 0, cmp_count = 0, cycles = 0;
  // Register index, reset, all-ones and all-zero readback
  logic [7:0] ix [10] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h74, 8'hF0, 8'hF1, 8'hF2, 8'hF4, 8'hF5};
  logic [7:0] rv [10] = '{8'h01, 8'h03, 8'hF0, 8'h06, 8'h02, 8'h8E, 8'h00, 8'hFF, 8'h00, 8'h00};
  logic [7:0] fv [10] = '{8'h01, 8'h0F, 8'hF8, 8'h0F, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h5B, 8'h5B};
  logic [7:0] zv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'hFC, 8'h00, 8'h00};
  // Mode values: polarity, swap, iface and burst mixes
  logic [7:0] ml [6] = '{8'h00, 8'h52, 8'h44, 8'h1C, 8'h64, 8'h28};
  // MFM and FM kbit/s by table and rate code
  logic [23:0] rt [3][4] = '{'{24'h1F40FA, 24'h12C096, 24'h0FA07D, 24'h3E8000},
    '{24'h1F40FA, 24'h1F40FA, 24'h0FA07D, 24'h3E8000},
    '{24'h1F40FA, 24'h7D0000, 24'h0FA07D, 24'h3E8000}};
  assign hready = hreadyout;
  flcfg_regs flcfg_regs_i (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .dev_active, .io_base, .io_base_valid, .irq_line_sel,
    .burst_en, .floppy_mode, .iface_mode, .second_drive_report, .boot_from_a, .tape_media_id,
    .drive_a_type_sel, .precomp_en, .mfm_rate_kbps, .fm_rate_kbps, .core_dma_req, .rate_code,
    .drive_num, .core_drive_sel, .core_motor_on, .core_write_gate, .core_write_data,
    .core_write_protect, .dma_req_out, .drive_sel_pin, .motor_on_pin, .write_gate_pin,
    .write_data_out, .drive_density_out, .write_protect_pin);
  flcfg_drive_model flcfg_drive_model_i (.wp_on, .pol_high, .write_protect_pin);
  // ------------------------------------------------------------
  // Clock, timeout and tasks
  // ------------------------------------------------------------
  initial begin
    forever #5 clock = ~clock;
  end
  // Sample ready and read data mid-cycle, away from the launching edge
  always @(negedge clock) begin
    rdy_s <= hready;
    rdat_s <= hrdata;
  end
  // Whole run is a few hundred cycles; a hang ends here
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One single word transfer; waits on hready in both phases
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    @(posedge clock);
    while (rdy_s !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clock);
    while (rdy_s !== 1'b1) @(posedge clock);
    rdv = rdat_s;
    hsel <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk($sformatf("reg %h", idx), rdv, {24'h0, exp});
  endtask
  // Move the rate code on an edge and let outputs settle
  task automatic set_rate(input int r);
    @(posedge clock);
    rate_code <= 2'(r);
    #1;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(ix[i], rv[i]);
    for (int i = 0; i < 10; i++) begin
      wr(ix[i], 8'hFF);
      rd(ix[i], fv[i]);
    end
    chk("base ones", {io_base_valid, io_base}, 13'h1FF8);
    chk("irq", irq_line_sel, 4'hF);
    for (int i = 0; i < 10; i++) begin
      wr(ix[i], 8'h00);
      rd(ix[i], zv[i]);
    end
    chk("base zero", {io_base_valid, io_base}, 13'h0000);
    rd(8'h31, 8'h00);
    $display("Test registers done");
    wr(8'h30, 8'h01);
    core_dma_req <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      wr(8'h74, 8'(c));
      chk("dma", dma_req_out, (c < 4) ? (32'h1 << c) : 32'h0);
    end
    wr(8'h74, 8'h01);
    wr(8'h30, 8'h00);
    chk("dma idle", {dev_active, dma_req_out}, 5'h00);
    $display("Test dma done");
    for (int i = 0; i < 6; i++) begin
      m = ml[i];
      wr(8'hF0, m);
      wr(8'hF1, 8'h00);
      e = m[4] ? 2'h2 : 2'h1;
      if (!m[6]) e = ~e;
      chk("drive sel", {drive_sel_pin, motor_on_pin}, {e, e});
      chk("write pins", {write_gate_pin, write_data_out}, {m[6], !m[6]});
      chk("burst", burst_en, !m[1]);
      chk("floppy", floppy_mode, m[0]);
      chk("iface", iface_mode, m[3:2]);
      chk("second", second_drive_report, !m[5] && m[3:2] == 2'h1);
      wr(8'hF1, 8'h02);
      chk("inhibit", {write_gate_pin, write_data_out}, 2'h3);
    end
    $display("Test mode done");
    for (int w = 0; w < 2; w++) begin
      wp_on <= w[0];
      wr(8'hF1, 8'h31);
      chk("media", {core_write_protect, boot_from_a, tape_media_id}, 4'hF);
      wr(8'hF1, 8'h40);
      chk("wp pin", {boot_from_a, core_write_protect}, {1'b0, w[0]});
    end
    $display("Test protect done");
    wr(8'hF0, 8'h40);
    for (int t = 0; t < 4; t++) begin
      for (int f = 0; f < 4; f++) begin
        wr(8'hF2, 8'(t));
        wr(8'hF4, 8'(t));
        wr(8'hF1, 8'(f << 2));
        for (int r = 0; r < 4; r++) begin
          set_rate(r);
          s = (r == 3 || r == 0);
          if (f >= 2) s = (f == 2);
          if (t == 1) s = r[1];
          if (t == 3) s = r[0];
          chk("density", drive_density_out, s);
        end
      end
    end
    for (int b = 0; b < 3; b++) begin
      wr(8'hF4, 8'(b << 3));
      for (int r = 0; r < 4; r++) begin
        set_rate(r);
        chk("rate", {mfm_rate_kbps, fm_rate_kbps}, rt[b][r]);
      end
    end
    wr(8'hF4, 8'h40);
    chk("precomp", precomp_en, 2'h2);
    chk("dtype a", drive_a_type_sel, 2'h3);
    $display("Test density done");
    stop_test();
  end
endmodule
